// >>> pkg/bcer_pkg.sv
// package: constants and types for the bridge clock and error status registers
package bcer_pkg;
// Behaviour
// - output zero disable in bits 1:0; 11 stops it high, other codes toggle
// - outputs one to three use bits 3:2, 5:4, 7:6; all reset enabled
// - clock control bits 13:9 read 0x1F, ignore writes
// - bit 16 records address parity error; bits 16 to 23 write-one-to-clear
// - bit 17 records posted write data parity error on target bus
// - bit 18 records posted write not delivered within retry limit
// - bit 19 records target abort while delivering posted write
// - bit 20 records master abort while delivering posted write
// - bit 21 records delayed write not delivered within retry limit
// - bit 22 records delayed read getting no data within retry limit
// - bit 23 records initiator not repeating delayed transaction before timeout
// - bit 24 reads one while secondary clock stopped, zero while running
// - bit 25 enables secondary clock-run, resets to zero
// - bit 26 zero lets primary clock stop after secondary; one keeps running
// - bit 27 enables primary clock-run, resets to zero
// - mode 0 stops secondary clock only on primary bus request
// - mode 1 stops secondary clock when idle and nothing pending from primary
// - bits 31:29 reserved, read zero, read-only
// - bit 8 and bits 15:14 read zero, ignore writes
// - event drives system error only if enable set and, except for bits 0 and 7 which ignore their disable input, not disabled

    localparam logic [7:0]  OFF_CLK_CTRL  = 8'h68;
    localparam logic [7:0]  OFF_CLK_RUN   = 8'h6C;
    localparam logic [1:0]  CLK_DIS_CODE  = 2'h3;
    localparam logic [7:0]  CLK_DIS_RST   = 8'h00;
    localparam logic [4:0]  CTL_RSVD_VAL  = 5'h1F;
    localparam logic [7:0]  STS_RST       = 8'h00;
    localparam logic [7:0]  DIS_VALID     = 8'h7E;
    localparam int          STS_LSB       = 16;
    localparam int          RUN_STOP_BIT  = 24;
    localparam int          RUN_SEN_BIT   = 25;
    localparam int          RUN_KEEP_BIT  = 26;
    localparam int          RUN_PEN_BIT   = 27;
    localparam int          RUN_MODE_BIT  = 28;
    localparam int          BE_CTL        = 0;
    localparam int          BE_STS        = 2;
    localparam int          BE_RUN        = 3;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be_n;
        logic [31:0] wdata;
    } bcer_cfg_req_t;

    typedef struct packed {
        logic sec_en;
        logic keep_pri;
        logic pri_en;
        logic mode;
    } bcer_run_ctl_t;

    typedef enum logic [1:0] {
        BCER_RUN     = 2'b00,
        BCER_PARK    = 2'b01,
        BCER_STOPPED = 2'b11,
        BCER_WAKE    = 2'b10
    } bcer_run_st_t;
endpackage

// >>> logic/bcer_clk_gate.sv
// secondary clock output generators with per-output disable and common stop
`timescale 1ns/1ps
module bcer_clk_gate #(
    parameter int N_OUT = 4
) (
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    input  wire logic [2*N_OUT-1:0] i_dis,
    input  wire logic               i_all_stop,
    output logic      [N_OUT-1:0]   o_clk_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    genvar g;
    generate
        for (g = 0; g < N_OUT; g++) begin : g_out
            wire  stop = (i_dis[2*g+1:2*g] == bcer_pkg::CLK_DIS_CODE) | i_all_stop;
            logic clk_q;
            // parked high so the stopped level is a clean high
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) clk_q <= 1'b1;
                else          clk_q <= stop ? 1'b1 : ~clk_q;
            end
            assign o_clk_out[g] = clk_q;

            clk_held_a: assert property (stop |=> o_clk_out[g])
                else $error("disabled clock output not held high");
            clk_toggle_a: assert property (!stop ##1 !stop |-> o_clk_out[g] != $past(o_clk_out[g]))
                else $error("enabled clock output not toggling");
        end
    endgenerate
endmodule // bcer_clk_gate

// >>> logic/bcer_clkrun.sv
// secondary clock-run stop and wake sequencer
`timescale 1ns/1ps
module bcer_clkrun (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_sec_en,
    input  wire logic i_mode,
    input  wire logic i_sec_idle,
    input  wire logic i_pri_req,
    input  wire logic i_pri_pend,
    output logic      o_stopped
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    bcer_pkg::bcer_run_st_t st_q;
    bcer_pkg::bcer_run_st_t st_d;
    wire stop_ok = i_sec_en & i_sec_idle & (i_mode ? ~i_pri_pend : i_pri_req);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            bcer_pkg::BCER_RUN:     if (stop_ok) st_d = bcer_pkg::BCER_PARK;
            bcer_pkg::BCER_PARK:    st_d = stop_ok ? bcer_pkg::BCER_STOPPED : bcer_pkg::BCER_RUN;
            bcer_pkg::BCER_STOPPED: if (!stop_ok) st_d = bcer_pkg::BCER_WAKE;
            bcer_pkg::BCER_WAKE:    st_d = bcer_pkg::BCER_RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) st_q <= bcer_pkg::BCER_RUN;
        else          st_q <= st_d;
    end

    // park covers the clock edge so outputs stop high, not mid-phase
    assign o_stopped = (st_q == bcer_pkg::BCER_PARK) | (st_q == bcer_pkg::BCER_STOPPED);

    sequence s_idle_mode1;
        i_sec_en && i_mode && i_sec_idle && !i_pri_pend;
    endsequence
    mode0_req_a: assert property ((st_q == bcer_pkg::BCER_RUN) && !i_mode && !i_pri_req
                                  |=> st_q == bcer_pkg::BCER_RUN)
        else $error("secondary clock stopped without primary request");
    mode1_idle_a: assert property (((st_q == bcer_pkg::BCER_RUN) ##0 s_idle_mode1) ##1 s_idle_mode1
                                   |=> o_stopped)
        else $error("idle secondary bus did not stop clock");
    disabled_run_a: assert property (!i_sec_en ##1 !i_sec_en |=> !o_stopped)
        else $error("clock stopped with clock-run disabled");
endmodule // bcer_clkrun

// >>> logic/bcer_regs.sv
// clock control, system error reason status and clock-run registers
`timescale 1ns/1ps
module bcer_regs #(
    parameter int N_OUT = 4
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire bcer_pkg::bcer_cfg_req_t i_cfg,
    output logic [31:0]                  o_cfg_rdata,
    output logic                         o_cfg_rvalid,
    input  wire logic [7:0]              i_err_event,
    input  wire logic [7:0]              i_event_disable,
    input  wire logic                    i_serr_enable,
    input  wire logic                    i_sec_bus_idle,
    input  wire logic                    i_pri_stop_req,
    input  wire logic                    i_pri_txn_pending,
    output logic                         o_secondary_clock_out_zero,
    output logic                         o_secondary_clock_out_one,
    output logic                         o_secondary_clock_out_two,
    output logic                         o_secondary_clock_out_three,
    output logic                         o_primary_system_error_n_o,
    output logic                         o_primary_system_error_n_oe,
    output logic                         o_pri_clk_stop_ok
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // ---- register state
    logic [7:0]              clk_dis_q;
    logic [7:0]              clk_dis_d;
    logic [7:0]              sts_q;
    logic [7:0]              sts_d;
    bcer_pkg::bcer_run_ctl_t run_q;
    bcer_pkg::bcer_run_ctl_t run_d;
    logic                    serr_oe_q;
    logic                    pri_stop_q;
    logic [31:0]             rdata_q;
    logic                    rvalid_q;
    logic                    sec_stopped;
    logic [N_OUT-1:0]        clk_out;

    // ---- address decode
    wire hit_ctl = (i_cfg.addr == bcer_pkg::OFF_CLK_CTRL);
    wire hit_run = (i_cfg.addr == bcer_pkg::OFF_CLK_RUN);

    // ---- byte-lane write strobes, byte enables are active low
    wire wr_ctl = i_cfg.wr & hit_ctl & ~i_cfg.be_n[bcer_pkg::BE_CTL];
    wire wr_sts = i_cfg.wr & hit_ctl & ~i_cfg.be_n[bcer_pkg::BE_STS];
    wire wr_run = i_cfg.wr & hit_run & ~i_cfg.be_n[bcer_pkg::BE_RUN];

    // ---- clock output disable fields
    // byte 1 holds only read-only reserved bits, so it has no strobe
    assign clk_dis_d = wr_ctl ? i_cfg.wdata[7:0] : clk_dis_q;

    // ---- error reason capture
    // address parity and master timeout have no disable bit of their own
    wire [7:0] ev_allowed = i_err_event & ~(i_event_disable & bcer_pkg::DIS_VALID);
    wire [7:0] sts_set    = ev_allowed & {8{i_serr_enable}};
    wire [7:0] sts_clr    = wr_sts ? i_cfg.wdata[bcer_pkg::STS_LSB +: 8] : 8'h00;
    // set wins over a simultaneous clear so no event is lost
    assign sts_d = sts_set | (sts_q & ~sts_clr);

    // ---- clock-run control byte
    wire [31:0] wd = i_cfg.wdata;
    always_comb begin
        run_d = run_q;
        if (wr_run) begin
            run_d.sec_en   = wd[bcer_pkg::RUN_SEN_BIT];
            run_d.keep_pri = wd[bcer_pkg::RUN_KEEP_BIT];
            run_d.pri_en   = wd[bcer_pkg::RUN_PEN_BIT];
            run_d.mode     = wd[bcer_pkg::RUN_MODE_BIT];
        end
    end

    // ---- primary clock stop permission
    wire pri_stop_d = run_q.pri_en & ~run_q.keep_pri & sec_stopped;

    // ---- read data assembly
    wire [31:0] rd_ctl = {8'h00,
                          sts_q,
                          2'b00,
                          bcer_pkg::CTL_RSVD_VAL,
                          1'b0,
                          clk_dis_q};
    wire [31:0] rd_run = {3'b000,
                          run_q.mode,
                          run_q.pri_en,
                          run_q.keep_pri,
                          run_q.sec_en,
                          sec_stopped,
                          24'h00_0000};
    // unmapped offsets answer with zero
    wire [31:0] rd_word = hit_ctl ? rd_ctl : (hit_run ? rd_run : 32'h0000_0000);

    // ---- registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_dis_q <= bcer_pkg::CLK_DIS_RST;
            sts_q     <= bcer_pkg::STS_RST;
            run_q     <= '0;
        end else begin
            clk_dis_q <= clk_dis_d;
            sts_q     <= sts_d;
            run_q     <= run_d;
        end
    end

    // serr drive goes out in the same cycle the reason bit lands
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            serr_oe_q  <= 1'b0;
            pri_stop_q <= 1'b0;
        end else begin
            serr_oe_q  <= |sts_set;
            pri_stop_q <= pri_stop_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= i_cfg.rd ? rd_word : 32'h0000_0000;
            rvalid_q <= i_cfg.rd;
        end
    end

    // ---- clock-run sequencer
    bcer_clkrun u_clkrun (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_sec_en   (run_q.sec_en),
        .i_mode     (run_q.mode),
        .i_sec_idle (i_sec_bus_idle),
        .i_pri_req  (i_pri_stop_req),
        .i_pri_pend (i_pri_txn_pending),
        .o_stopped  (sec_stopped)
    );

    // ---- secondary clock outputs
    bcer_clk_gate #(
        .N_OUT (N_OUT)
    ) u_clk_gate (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_dis      (clk_dis_q),
        .i_all_stop (sec_stopped),
        .o_clk_out  (clk_out)
    );

    // ---- outputs
    assign o_secondary_clock_out_zero  = clk_out[0];
    assign o_secondary_clock_out_one   = clk_out[1];
    assign o_secondary_clock_out_two   = clk_out[2];
    assign o_secondary_clock_out_three = clk_out[3];
    // open drain: only ever pulls low
    assign o_primary_system_error_n_o  = 1'b0;
    assign o_primary_system_error_n_oe = serr_oe_q;
    assign o_pri_clk_stop_ok           = pri_stop_q;
    assign o_cfg_rdata                 = rdata_q;
    assign o_cfg_rvalid                = rvalid_q;

    // ---- checks
    sequence s_rd_ctl;
        i_cfg.rd && hit_ctl;
    endsequence

    sequence s_rd_run;
        i_cfg.rd && hit_run;
    endsequence

    sequence s_ev0;
        i_err_event[0] && i_serr_enable;
    endsequence

    rsvd_ctl_a: assert property (s_rd_ctl |=> o_cfg_rdata[13:9] == 5'h1F)
        else $error("clock control reserved field not 0x1F");

    zero_ctl_a: assert property (s_rd_ctl |=> !o_cfg_rdata[8] && o_cfg_rdata[15:14] == 2'b00)
        else $error("clock control reserved bits not zero");

    rsvd_run_a: assert property (s_rd_run |=> o_cfg_rdata[31:29] == 3'b000)
        else $error("clock-run reserved bits not zero");

    addr_par_a: assert property (s_ev0 |=> sts_q[0] && o_primary_system_error_n_oe)
        else $error("address parity reason or error drive missing");

    pw_par_a: assert property (i_err_event[1] && !i_event_disable[1] && i_serr_enable
                               |=> sts_q[1])
        else $error("posted write parity reason not recorded");

    pw_nodel_a: assert property (i_err_event[2] && !i_event_disable[2] && i_serr_enable
                                 |=> sts_q[2])
        else $error("posted write nondelivery reason not recorded");

    tabort_a: assert property (i_err_event[3] && !i_event_disable[3] && i_serr_enable
                               |=> sts_q[3])
        else $error("target abort reason not recorded");

    mabort_a: assert property (i_err_event[4] && !i_event_disable[4] && i_serr_enable
                               |=> sts_q[4])
        else $error("master abort reason not recorded");

    dw_nodel_a: assert property (i_err_event[5] && !i_event_disable[5] && i_serr_enable
                                 |=> sts_q[5])
        else $error("delayed write nondelivery reason not recorded");

    dr_nodata_a: assert property (i_err_event[6] && !i_event_disable[6] && i_serr_enable
                                  |=> sts_q[6])
        else $error("delayed read no-data reason not recorded");

    mtimeout_a: assert property (i_err_event[7] && i_serr_enable |=> sts_q[7])
        else $error("master timeout reason not recorded");

    serr_gate_a: assert property (!i_serr_enable |=> !o_primary_system_error_n_oe)
        else $error("system error driven while disabled");

    sts_hold_a: assert property (sts_q[0] && !(wr_sts && i_cfg.wdata[16]) |=> sts_q[0])
        else $error("reason bit lost without a clear");

    sts_clear_a: assert property (wr_sts && i_cfg.wdata[16] && !sts_set[0] |=> !sts_q[0])
        else $error("write one did not clear reason bit");

    stop_sts_a: assert property (s_rd_run |=> o_cfg_rdata[24] == $past(sec_stopped))
        else $error("stop status bit does not follow clock state");

    keep_pri_a: assert property (run_q.keep_pri |=> !o_pri_clk_stop_ok)
        else $error("primary clock allowed to stop while kept running");

    pen_a: assert property (wr_run ##1 s_rd_run |=> o_cfg_rdata[27] == $past(run_q.pri_en))
        else $error("primary clock-run enable readback wrong");

    sen_a: assert property (wr_run |=> run_q.sec_en == $past(i_cfg.wdata[25]))
        else $error("secondary clock-run enable not written");

    dis_wr_a: assert property (wr_ctl |=> clk_dis_q == $past(i_cfg.wdata[7:0]))
        else $error("clock disable fields not written");
endmodule // bcer_regs

// >>> tb/bcer_host_model.sv
// host side model issuing primary configuration accesses and pulling up the error line
`timescale 1ns/1ps
module bcer_host_model (
    input  wire logic                    i_clk,
    output bcer_pkg::bcer_cfg_req_t      o_cfg,
    input  wire logic [31:0]             i_cfg_rdata,
    input  wire logic                    i_cfg_rvalid,
    input  wire logic                    i_serr_n_o,
    input  wire logic                    i_serr_n_oe,
    output logic                         o_serr_n
);
    // open-drain error line with board pull-up
    assign o_serr_n = i_serr_n_oe ? i_serr_n_o : 1'b1;

    initial begin
        o_cfg = '0;
        o_cfg.be_n = 4'hF;
    end

    // released bus shows inverted data, not the last value
    task automatic release_bus();
        o_cfg.wr = 1'b0;
        o_cfg.rd = 1'b0;
        o_cfg.addr = ~o_cfg.addr;
        o_cfg.wdata = ~o_cfg.wdata;
        o_cfg.be_n = 4'hF;
    endtask

    // called at a falling edge; one access taken at the next rising edge
    task automatic cfg_write(input logic [7:0] addr, input logic [3:0] be_n, input logic [31:0] data);
        o_cfg.wr = 1'b1;
        o_cfg.addr = addr;
        o_cfg.be_n = be_n;
        o_cfg.wdata = data;
        @(negedge i_clk);
        release_bus();
        @(negedge i_clk);
    endtask

    task automatic cfg_read(input logic [7:0] addr, output logic [31:0] data, output logic valid);
        o_cfg.rd = 1'b1;
        o_cfg.addr = addr;
        o_cfg.be_n = 4'h0;
        @(negedge i_clk);
        data = i_cfg_rdata;
        valid = i_cfg_rvalid;
        release_bus();
        @(negedge i_clk);
    endtask
endmodule // bcer_host_model

// >>> tb/tb_top.sv
// self-checking bench for the clock control, error status and clock-run registers
`timescale 1ns/1ps
module tb_top;
    logic                    clk;
    logic                    rst_n;
    bcer_pkg::bcer_cfg_req_t cfg;
    logic [31:0]             rdata;
    logic                    rvalid;
    logic [7:0]              ev;
    logic [7:0]              dis;
    logic                    serr_en;
    logic                    idle;
    logic                    stop_req;
    logic                    pend;
    logic [3:0]              cko;
    logic                    serr_o;
    logic                    serr_oe;
    logic                    serr_n;
    logic                    stop_ok;
    int                      num_errors;
    int                      n_tests;
    int                      cycles;
    logic [31:0]             rd_v;
    logic                    rd_ok;
    logic [3:0]              smp;

    bcer_regs #(.N_OUT(4)) bcer_regs_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_err_event(ev), .i_event_disable(dis), .i_serr_enable(serr_en), .i_sec_bus_idle(idle),
        .i_pri_stop_req(stop_req), .i_pri_txn_pending(pend),
        .o_secondary_clock_out_zero(cko[0]), .o_secondary_clock_out_one(cko[1]),
        .o_secondary_clock_out_two(cko[2]), .o_secondary_clock_out_three(cko[3]),
        .o_primary_system_error_n_o(serr_o), .o_primary_system_error_n_oe(serr_oe),
        .o_pri_clk_stop_ok(stop_ok));

    bcer_host_model bcer_host_model_inst (
        .i_clk(clk), .o_cfg(cfg), .i_cfg_rdata(rdata), .i_cfg_rvalid(rvalid),
        .i_serr_n_o(serr_o), .i_serr_n_oe(serr_oe), .o_serr_n(serr_n));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // read a register and compare data and valid together
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bcer_host_model_inst.cfg_read(a, rd_v, rd_ok);
        check({rd_v[31:1], rd_v[0] & rd_ok}, {exp[31:1], exp[0] & 1'b1});
        check({31'h0, rd_ok}, 32'h0000_0001);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be_n, input logic [31:0] d);
        bcer_host_model_inst.cfg_write(a, be_n, d);
    endtask

    // toggling outputs differ on consecutive cycles; stopped ones stay high
    task automatic clk_chk(input logic [3:0] tog);
        smp = cko;
        @(negedge clk);
        check({28'h0, smp ^ cko}, {28'h0, tog});
        check({28'h0, cko | tog}, 32'h0000_000F);
    endtask

    task automatic pulse(input logic [7:0] e, input logic low);
        ev = e;
        @(negedge clk);
        ev = 8'h00;
        check({31'h0, serr_n}, {31'h0, ~low});
        @(negedge clk);
        check({31'h0, serr_n}, 32'h0000_0001);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        rst_n = 1'b0;
        ev = 8'h00;
        dis = 8'h00;
        serr_en = 1'b1;
        idle = 1'b0;
        stop_req = 1'b0;
        pend = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rd_chk(8'h68, 32'h0000_3E00);
        rd_chk(8'h6C, 32'h0000_0000);
        clk_chk(4'hF);
        wr(8'h68, 4'h0, 32'h0000_FFE4);
        rd_chk(8'h68, 32'h0000_3EE4);
        clk_chk(4'h7);
        wr(8'h68, 4'h1, 32'h0000_00FF);
        rd_chk(8'h68, 32'h0000_3EE4);
        wr(8'h68, 4'h0, 32'h0000_00FF);
        clk_chk(4'h0);
        wr(8'h68, 4'h0, 32'h0000_0000);
        clk_chk(4'hF);
        wr(8'h70, 4'h0, 32'hFFFF_FFFF);
        rd_chk(8'h70, 32'h0000_0000);
        // every reason bit recorded, then cleared by its own one
        for (int n = 0; n < 8; n++) begin
            pulse(8'h01 << n, 1'b1);
            rd_chk(8'h68, 32'h0000_3E00 | (32'h1 << (16 + n)));
            wr(8'h68, 4'hB, 32'h1 << (16 + n));
            rd_chk(8'h68, 32'h0000_3E00);
        end
        dis = 8'hFF;
        pulse(8'hFF, 1'b1);
        rd_chk(8'h68, 32'h0081_3E00);
        wr(8'h68, 4'hB, 32'h00FF_0000);
        dis = 8'h00;
        serr_en = 1'b0;
        pulse(8'hFF, 1'b0);
        rd_chk(8'h68, 32'h0000_3E00);
        serr_en = 1'b1;
        pulse(8'h04, 1'b1);
        fork
            wr(8'h68, 4'hB, 32'h0004_0000);
            begin
                ev = 8'h04;
                @(negedge clk);
                ev = 8'h00;
            end
        join
        rd_chk(8'h68, 32'h0004_3E00);
        wr(8'h68, 4'hB, 32'h0004_0000);
        // clock-run, idle mode with primary clock kept running, then allowed to stop
        wr(8'h6C, 4'h0, 32'hFE00_0000);
        rd_chk(8'h6C, 32'h1E00_0000);
        idle = 1'b1;
        repeat (3) @(negedge clk);
        rd_chk(8'h6C, 32'h1F00_0000);
        clk_chk(4'h0);
        check({31'h0, stop_ok}, 32'h0000_0000);
        wr(8'h6C, 4'h0, 32'h1A00_0000);
        repeat (2) @(negedge clk);
        check({31'h0, stop_ok}, 32'h0000_0001);
        pend = 1'b1;
        repeat (3) @(negedge clk);
        rd_chk(8'h6C, 32'h1A00_0000);
        check({31'h0, stop_ok}, 32'h0000_0000);
        // request mode: idle alone must not stop the clock
        wr(8'h6C, 4'h0, 32'h0A00_0000);
        pend = 1'b0;
        repeat (4) @(negedge clk);
        rd_chk(8'h6C, 32'h0A00_0000);
        stop_req = 1'b1;
        repeat (3) @(negedge clk);
        rd_chk(8'h6C, 32'h0B00_0000);
        wr(8'h6C, 4'h0, 32'h0800_0000);
        repeat (3) @(negedge clk);
        rd_chk(8'h6C, 32'h0800_0000);
        clk_chk(4'hF);
        // mid-run reset must bring every register back to its reset value
        rst_n = 1'b0;
        @(negedge clk);
        check({28'h0, cko}, 32'h0000_000F);
        check({31'h0, stop_ok}, 32'h0000_0000);
        rst_n = 1'b1;
        rd_chk(8'h6C, 32'h0000_0000);
        rd_chk(8'h68, 32'h0000_3E00);
        clk_chk(4'hF);
        conclude();
    end
endmodule // tb_top
